//--- hdl/wdt_pkg.sv
/*
 * constants for the guard timer and periodic timer block: key values,
 * control field positions, reset values and tap selections.
 * assumes a single clock domain; guard_clock arrives as a synchronous level.
 */
`default_nettype none

package wdt_pkg;

	// ------------------------------------------------------------
	// key values
	// ------------------------------------------------------------
	localparam logic [7:0] WDT_KEY_ARM = 8'h55;
	localparam logic [7:0] WDT_KEY_CLEAR = 8'hAA;

	// ------------------------------------------------------------
	// guard_control fields
	// ------------------------------------------------------------
	localparam int WDT_GC_FLAG_BIT = 7;
	localparam int WDT_GC_DIS_BIT = 6;
	localparam int WDT_GC_CHK_HI = 5;
	localparam int WDT_GC_CHK_LO = 3;
	localparam int WDT_GC_PS_HI = 2;
	localparam int WDT_GC_PS_LO = 0;
	localparam logic [2:0] WDT_CHECK_PATTERN = 3'h5;
	localparam logic [2:0] WDT_GC_PS_RESET = 3'h0;
	localparam logic WDT_GC_DIS_RESET = 1'b0;
	localparam logic WDT_GC_FLAG_RESET = 1'b0;

	// ------------------------------------------------------------
	// periodic_control fields
	// ------------------------------------------------------------
	localparam int WDT_PC_FLAG_BIT = 7;
	localparam int WDT_PC_EN_BIT = 6;
	localparam int WDT_PC_PS_HI = 2;
	localparam int WDT_PC_PS_LO = 0;
	localparam logic [7:0] WDT_PC_RESET = 8'h00;

	// ------------------------------------------------------------
	// counters and taps
	// ------------------------------------------------------------
	localparam int WDT_FREE_W = 7;
	localparam logic [7:0] WDT_COUNT_RESET = 8'h00;
	localparam logic [WDT_FREE_W-1:0] WDT_FREE_RESET = 7'h00;
	// periodic selector: low bits of free counter or periodic counter that
	// must be all ones for the tap to carry
	localparam logic [2:0] WDT_PSEL_FIRST_COUNT = 3'h4;
	localparam logic [3:0] WDT_PTAP_FREE0 = 4'h2;
	localparam logic [3:0] WDT_PTAP_FREE1 = 4'h4;
	localparam logic [3:0] WDT_PTAP_FREE2 = 4'h6;
	localparam logic [3:0] WDT_PTAP_FREE3 = 4'h7;
	localparam logic [3:0] WDT_PTAP_CNT0 = 4'h1;
	localparam logic [3:0] WDT_PTAP_CNT1 = 4'h3;
	localparam logic [3:0] WDT_PTAP_CNT2 = 4'h5;
	localparam logic [3:0] WDT_PTAP_CNT3 = 4'h7;

	typedef enum logic [1:0] {
		WDT_RUN = 2'b00,
		WDT_OVF_WAIT = 2'b01,
		WDT_RESET = 2'b10
	} wdt_state_t;

endpackage

`default_nettype wire

//--- hdl/wdt_timer.sv
/*
 * guard timer and periodic interrupt timer, one module.
 * assumes guard_clock is a slow level synchronous to ref_clk, sys_rst is the
 * system reset that guard_reset_req feeds, and por_rst is power-on only.
 */
// Notes on behaviour
// R1 - guard count is an 8-bit up-counter stepped by the selected prescaler output
// R2 - guard logic runs on every rising edge of guard_clock, regardless of any setting
// R3 - guard count value is readable at any time
// R4 - 3-bit prescale picks raw guard clock or one of six free-counter taps
// R5 - free-running counter only cleared by system reset, never by counter clears
// R6 - writing 55h arms the clear; repeats keep armed; lone AAh does nothing
// R7 - AAh while armed clears the guard count to zero
// R8 - any other key value asserts system reset immediately
// R9 - software must write 55h then AAh before overflow and set up early
// R10 - overflow and illegal key both set the reset cause flag
// R11 - a set cause flag never blocks later resets; software clears it
// R12 - overflow reset follows one guard count clock period after overflow
// R13 - overflow reset cannot be disabled in normal operation
// R14 - disabled only if pin high during reset and disable bit set
// R15 - check bits compared with 101 continuously; mismatch resets system
// R16 - software writes 101 into the check bits on every control write
// R17 - after reset prescale is fastest and counting starts at once
// R18 - 3-bit field picks among four periodic and four free-counter taps
// R19 - periodic count steps on the divide-by-128 tap of the free counter
// R20 - periodic rates span 1 to 4096 per second at 16384 Hz
// R21 - periodic count readable or clearable any time, free counter untouched
// R22 - periodic functions stop only in halt; a software bit enables requests
// R23 - one request per transition of the selected tap when enabled
// R24 - overflow flag sets on overflow, cleared by writing 0, set by software silently
// R25 - reading the key location returns the guard control contents
// R26 - 8-bit peripheral on 16-bit bus: upper write byte ignored, upper read zero
// R27 - armed state cleared by the clearing AAh write and by system reset
// R28 - system reset zeroes free, guard and periodic counters
`timescale 1ns/1ps
`default_nettype none

module wdt_timer
	import wdt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic por_rst,
	input wire logic guard_clock,
	input wire logic programming_voltage_pin,
	input wire logic halt_mode,
	input wire logic [15:0] wr_data,
	input wire logic service_key_wr,
	input wire logic guard_control_wr,
	input wire logic periodic_control_wr,
	input wire logic periodic_count_wr,
	output logic [15:0] guard_count_rd,
	output logic [15:0] periodic_count_rd,
	output logic [15:0] service_key_rd,
	output logic [15:0] guard_control_rd,
	output logic [15:0] periodic_control_rd,
	output logic guard_reset_req,
	output logic periodic_irq
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// true when the low n bits of v are all ones (carry into bit n)
	function automatic logic low_ones(input logic [7:0] v, input logic [3:0] n);
		logic r;
		r = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(n) && !v[i]) begin
				r = 1'b0;
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic rst;
	logic guard_clock_reg;
	logic tick;
	logic [WDT_FREE_W-1:0] free_reg;
	logic [7:0] guard_count_reg;
	logic [7:0] periodic_count_reg;
	logic armed_reg;
	logic guard_flag_reg;
	logic guard_dis_reg;
	logic [2:0] guard_chk_reg;
	logic [2:0] guard_ps_reg;
	logic pin_latched_reg;
	logic periodic_flag_reg;
	logic periodic_en_reg;
	logic [2:0] periodic_ps_reg;
	logic periodic_irq_reg;
	logic guard_reset_reg;
	wdt_state_t state_reg;
	logic [7:0] wdata;
	logic guard_step;
	logic periodic_step;
	logic periodic_tap;
	logic key_arm;
	logic key_clear;
	logic key_bad;
	logic check_bad;
	logic overflow;
	logic guard_disabled;
	logic [7:0] guard_control;
	logic [7:0] periodic_control;

	assign rst = sys_rst | por_rst;
	assign wdata = wr_data[7:0]; // R26

	// ------------------------------------------------------------
	// guard clock edge and free-running counter
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			guard_clock_reg <= 1'b0;
		end else begin
			guard_clock_reg <= guard_clock;
		end
	end

	assign tick = guard_clock & ~guard_clock_reg; // R2

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			free_reg <= WDT_FREE_RESET; // R28
		end else if (tick) begin
			free_reg <= free_reg + 7'h01; // R5
		end
	end

	// ------------------------------------------------------------
	// prescale selection
	// ------------------------------------------------------------
	always_comb begin
		if (guard_ps_reg < 3'h2) begin
			guard_step = tick; // R4
		end else begin
			guard_step = tick & low_ones({1'b0, free_reg}, {1'b0, guard_ps_reg - 3'h1}); // R4
		end
	end

	assign periodic_step = tick & low_ones({1'b0, free_reg}, 4'(WDT_FREE_W)); // R19

	always_comb begin
		case (periodic_ps_reg)
			3'h0: periodic_tap = tick & low_ones({1'b0, free_reg}, WDT_PTAP_FREE0); // R18
			3'h1: periodic_tap = tick & low_ones({1'b0, free_reg}, WDT_PTAP_FREE1);
			3'h2: periodic_tap = tick & low_ones({1'b0, free_reg}, WDT_PTAP_FREE2);
			3'h3: periodic_tap = tick & low_ones({1'b0, free_reg}, WDT_PTAP_FREE3);
			3'h4: periodic_tap = periodic_step & low_ones(periodic_count_reg, WDT_PTAP_CNT0);
			3'h5: periodic_tap = periodic_step & low_ones(periodic_count_reg, WDT_PTAP_CNT1);
			3'h6: periodic_tap = periodic_step & low_ones(periodic_count_reg, WDT_PTAP_CNT2);
			3'h7: periodic_tap = periodic_step & low_ones(periodic_count_reg, WDT_PTAP_CNT3); // R20
			default: periodic_tap = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// key logic
	// ------------------------------------------------------------
	assign key_arm = service_key_wr && wdata == WDT_KEY_ARM; // R6
	assign key_clear = service_key_wr && wdata == WDT_KEY_CLEAR && armed_reg; // R7
	assign key_bad = service_key_wr && wdata != WDT_KEY_ARM && wdata != WDT_KEY_CLEAR; // R8

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			armed_reg <= 1'b0; // R27
		end else if (key_arm) begin
			armed_reg <= 1'b1; // R6
		end else if (key_clear) begin
			armed_reg <= 1'b0; // R27
		end
	end

	// ------------------------------------------------------------
	// guard counter
	// ------------------------------------------------------------
	assign guard_disabled = pin_latched_reg & guard_dis_reg; // R14
	assign overflow = guard_step && guard_count_reg == 8'hFF && !guard_disabled; // R13

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			guard_count_reg <= WDT_COUNT_RESET; // R17
		end else if (key_clear) begin
			guard_count_reg <= WDT_COUNT_RESET; // R7
		end else if (guard_step && !guard_disabled) begin
			guard_count_reg <= guard_count_reg + 8'h01; // R1
		end
	end

	// pin level caught while reset is held
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_latched_reg <= programming_voltage_pin; // R14
		end
	end

	// ------------------------------------------------------------
	// guard control register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			guard_dis_reg <= WDT_GC_DIS_RESET;
			guard_chk_reg <= WDT_CHECK_PATTERN;
			guard_ps_reg <= WDT_GC_PS_RESET; // R17
		end else if (guard_control_wr) begin
			guard_dis_reg <= wdata[WDT_GC_DIS_BIT];
			guard_chk_reg <= wdata[WDT_GC_CHK_HI:WDT_GC_CHK_LO]; // R16
			guard_ps_reg <= wdata[WDT_GC_PS_HI:WDT_GC_PS_LO];
		end
	end

	// cause flag survives system reset; only power-on reset or a software write of 0 clears it
	always_ff @(posedge ref_clk) begin
		if (por_rst) begin
			guard_flag_reg <= WDT_GC_FLAG_RESET;
		end else if (key_bad || overflow) begin
			guard_flag_reg <= 1'b1; // R10
		end else if (guard_control_wr && !wdata[WDT_GC_FLAG_BIT]) begin
			guard_flag_reg <= 1'b0; // R11
		end
	end

	assign check_bad = guard_chk_reg != WDT_CHECK_PATTERN; // R15

	// ------------------------------------------------------------
	// reset sequencing
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= WDT_RUN;
		end else begin
			case (state_reg)
				WDT_RUN: begin
					if (key_bad || check_bad) begin
						state_reg <= WDT_RESET; // R8
					end else if (overflow) begin
						state_reg <= WDT_OVF_WAIT; // R12
					end
				end
				WDT_OVF_WAIT: begin
					if (guard_step || key_bad || check_bad) begin
						state_reg <= WDT_RESET; // R12
					end
				end
				WDT_RESET: state_reg <= WDT_RESET; // R11
				default: state_reg <= WDT_RUN;
			endcase
		end
	end

	always_comb begin
		guard_reset_reg = state_reg == WDT_RESET;
	end

	assign guard_reset_req = guard_reset_reg;

	// ------------------------------------------------------------
	// periodic counter and control
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			periodic_count_reg <= WDT_COUNT_RESET; // R28
		end else if (periodic_count_wr) begin
			periodic_count_reg <= WDT_COUNT_RESET; // R21
		end else if (periodic_step && !halt_mode) begin
			periodic_count_reg <= periodic_count_reg + 8'h01; // R19
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			periodic_en_reg <= WDT_PC_RESET[WDT_PC_EN_BIT];
			periodic_ps_reg <= WDT_PC_RESET[WDT_PC_PS_HI:WDT_PC_PS_LO];
		end else if (periodic_control_wr) begin
			periodic_en_reg <= wdata[WDT_PC_EN_BIT]; // R22
			periodic_ps_reg <= wdata[WDT_PC_PS_HI:WDT_PC_PS_LO]; // R18
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			periodic_flag_reg <= WDT_PC_RESET[WDT_PC_FLAG_BIT];
		end else if (periodic_tap && !halt_mode) begin
			periodic_flag_reg <= 1'b1; // R24
		end else if (periodic_control_wr) begin
			periodic_flag_reg <= wdata[WDT_PC_FLAG_BIT]; // R24
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			periodic_irq_reg <= 1'b0;
		end else begin
			periodic_irq_reg <= periodic_tap & periodic_en_reg & ~halt_mode; // R23
		end
	end

	assign periodic_irq = periodic_irq_reg;

	// ------------------------------------------------------------
	// read values
	// ------------------------------------------------------------
	assign guard_control = {guard_flag_reg, guard_dis_reg, guard_chk_reg, guard_ps_reg};
	assign periodic_control = {periodic_flag_reg, periodic_en_reg, 3'h0, periodic_ps_reg};
	assign guard_count_rd = {8'h00, guard_count_reg}; // R3
	assign periodic_count_rd = {8'h00, periodic_count_reg}; // R21
	assign service_key_rd = {8'h00, guard_control}; // R25
	assign guard_control_rd = {8'h00, guard_control}; // R26
	assign periodic_control_rd = {8'h00, periodic_control};

endmodule

`default_nettype wire

//--- tb/wdt_properties.sv
/* port assertions and covers for wdt_timer.
 bound into every wdt_timer instance; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module wdt_properties
	import wdt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic por_rst,
	input wire logic guard_clock,
	input wire logic programming_voltage_pin,
	input wire logic halt_mode,
	input wire logic [15:0] wr_data,
	input wire logic service_key_wr,
	input wire logic guard_control_wr,
	input wire logic periodic_control_wr,
	input wire logic periodic_count_wr,
	input wire logic [15:0] guard_count_rd,
	input wire logic [15:0] periodic_count_rd,
	input wire logic [15:0] service_key_rd,
	input wire logic [15:0] guard_control_rd,
	input wire logic [15:0] periodic_control_rd,
	input wire logic guard_reset_req,
	input wire logic periodic_irq
);
	logic armed_reg;
	wire logic arm = service_key_wr && wr_data[7:0] == WDT_KEY_ARM;
	wire logic clr = service_key_wr && wr_data[7:0] == WDT_KEY_CLEAR;
	wire logic bad = service_key_wr && !arm && !clr;
	always_ff @(posedge ref_clk) begin
		if (sys_rst || por_rst) begin
			armed_reg <= 1'b0;
		end else if (arm || clr) begin
			armed_reg <= arm;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst || por_rst);
	a_key_clears_count: assert property (clr && armed_reg |=> guard_count_rd[7:0] == 8'h00)
		else $error("guard count not cleared by key");
	a_bad_key_reset: assert property (bad |=> guard_reset_req)
		else $error("no reset after bad key");
	a_bad_key_flag: assert property (bad |=> guard_control_rd[WDT_GC_FLAG_BIT])
		else $error("cause flag not set by bad key");
	a_check_mismatch: assert property (guard_control_rd[5:3] != WDT_CHECK_PATTERN |=>
		guard_reset_req) else $error("no reset on check bits");
	a_key_reads_control: assert property (service_key_rd == guard_control_rd)
		else $error("key read differs from control");
	a_upper_byte_zero: assert property ({guard_count_rd[15:8], periodic_count_rd[15:8],
		service_key_rd[15:8], guard_control_rd[15:8], periodic_control_rd[15:8]} == 40'h0)
		else $error("upper byte not zero");
	a_count_steps: assert property (!$stable(guard_count_rd) |->
		guard_count_rd[7:0] == $past(guard_count_rd[7:0]) + 8'h01 || guard_count_rd[7:0] == 8'h00)
		else $error("guard count jumped");
	a_irq_single: assert property (periodic_irq |=> !periodic_irq)
		else $error("irq longer than one cycle");
	a_irq_sets_flag: assert property (periodic_irq |-> periodic_control_rd[WDT_PC_FLAG_BIT])
		else $error("irq without flag");
	a_irq_needs_enable: assert property (periodic_irq |->
		$past(periodic_control_rd[WDT_PC_EN_BIT]) && !$past(halt_mode))
		else $error("irq while disabled or halted");
	c_irq: cover property (periodic_irq);
	c_reset: cover property ($rose(guard_reset_req));
	c_key_clear: cover property (clr && armed_reg);
endmodule
bind wdt_timer wdt_properties chk (.ref_clk, .sys_rst, .por_rst, .guard_clock,
	.programming_voltage_pin, .halt_mode, .wr_data, .service_key_wr, .guard_control_wr,
	.periodic_control_wr, .periodic_count_wr, .guard_count_rd, .periodic_count_rd,
	.service_key_rd, .guard_control_rd, .periodic_control_rd, .guard_reset_req, .periodic_irq);
`default_nettype wire

//--- tb/wdt_cpu_model.sv
/* software-side writer: turns one request into one write strobe.
 request is held one cycle by the caller; idle data bus toggles. */
`timescale 1ns/1ps
`default_nettype none
module wdt_cpu_model (
	input wire logic ref_clk,
	input wire logic req,
	input wire logic [1:0] kind,
	input wire logic [7:0] data,
	input wire logic raw,
	output logic [15:0] wr_data = 16'h0000,
	output logic service_key_wr = 1'b0,
	output logic guard_control_wr = 1'b0,
	output logic periodic_control_wr = 1'b0,
	output logic periodic_count_wr = 1'b0
);
	logic [7:0] val;
	always_comb begin
		val = data;
		if (kind == 2'h1 && !raw) begin
			val[5:3] = 3'h5;
		end
	end
	always_ff @(posedge ref_clk) begin
		wr_data <= req ? {~val, val} : ~wr_data;
		service_key_wr <= req && kind == 2'h0;
		guard_control_wr <= req && kind == 2'h1;
		periodic_control_wr <= req && kind == 2'h2;
		periodic_count_wr <= req && kind == 2'h3;
	end
endmodule
`default_nettype wire

//--- tb/wdt_timer_test.sv
/* self-checking bench for wdt_timer driven through the writer model.
 needs the package, writer model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module wdt_timer_test;
	typedef struct {
		logic [2:0] sel;
		int win;
		int n;
	} wdt_row_t;
	logic ref_clk = 1'b0, sys_rst = 1'b1, por_rst = 1'b1, guard_clock = 1'b0;
	logic pin = 1'b1, halt_mode = 1'b0, req = 1'b0, raw = 1'b0;
	logic [1:0] kind = 2'h0;
	logic [7:0] data = 8'h00;
	wire logic [15:0] wr_data, gcnt, pcnt, krd, gctl, pctl;
	wire logic key_wr, gc_wr, pc_wr, pn_wr, req_out, irq;
	int num_errors = 0, n_tests = 0, cycles = 0;
	wdt_row_t rows[8] = '{'{3'h0, 64, 8}, '{3'h1, 256, 8}, '{3'h2, 512, 4}, '{3'h3, 1024, 4},
		'{3'h4, 1024, 2}, '{3'h5, 4096, 2}, '{3'h6, 16384, 2}, '{3'h7, 32768, 1}};
	logic [7:0] keys[10] = '{8'hAA, 8'hAA, 8'h55, 8'h55, 8'h55, 8'hAA, 8'hAA, 8'h55, 8'hAA, 8'h55};
	logic [0:9] clr = 10'b0000010010;
	wdt_cpu_model cpu (.ref_clk(ref_clk), .req(req), .kind(kind), .data(data), .raw(raw),
		.wr_data(wr_data), .service_key_wr(key_wr), .guard_control_wr(gc_wr),
		.periodic_control_wr(pc_wr), .periodic_count_wr(pn_wr));
	wdt_timer uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .por_rst(por_rst),
		.guard_clock(guard_clock), .programming_voltage_pin(pin), .halt_mode(halt_mode),
		.wr_data(wr_data), .service_key_wr(key_wr), .guard_control_wr(gc_wr),
		.periodic_control_wr(pc_wr), .periodic_count_wr(pn_wr), .guard_count_rd(gcnt),
		.periodic_count_rd(pcnt), .service_key_rd(krd), .guard_control_rd(gctl),
		.periodic_control_rd(pctl), .guard_reset_req(req_out), .periodic_irq(irq));
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		guard_clock <= ~guard_clock;
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			finish_test();
		end
	end
	task automatic check(input logic ok, input string what);
		n_tests++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	task automatic wr(input logic [1:0] k, input logic [7:0] d);
		@(posedge ref_clk);
		kind <= k;
		data <= d;
		req <= 1'b1;
		@(posedge ref_clk);
		req <= 1'b0;
		@(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	task automatic do_reset(input logic p, input logic por);
		@(posedge ref_clk);
		pin <= p;
		sys_rst <= 1'b1;
		por_rst <= por;
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		por_rst <= 1'b0;
		@(negedge ref_clk);
	endtask
	task automatic done(input string name);
		$display("test %s done, mismatches %0d", name, num_errors);
	endtask
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		int n;
		logic [7:0] hold;
		do_reset(1'b1, 1'b1);
		check(gcnt === 16'h0000 && gctl === 16'h0028 && pctl === 16'h0000, "reset");
		repeat (20) @(negedge ref_clk);
		check(gcnt > 16'h0008 && gcnt < 16'h000C, "counting after reset");
		wr(2'h1, 8'h68);
		hold = gcnt[7:0];
		foreach (rows[i]) begin
			wr(2'h2, {5'h08, rows[i].sel});
			n = 0;
			repeat (rows[i].win) begin
				@(negedge ref_clk);
				if (irq === 1'b1) begin
					n++;
				end
			end
			check(n == rows[i].n, "periodic rate");
		end
		check(req_out === 1'b0 && gcnt[7:0] === hold, "disabled guard");
		done("periodic select");
		@(posedge ref_clk);
		halt_mode <= 1'b1;
		wr(2'h2, 8'h40);
		check(pctl === 16'h0040, "flag clear");
		hold = pcnt[7:0];
		wr(2'h2, 8'hC0);
		n = 0;
		repeat (600) begin
			@(negedge ref_clk);
			if (irq === 1'b1) begin
				n++;
			end
		end
		check(n == 0 && pctl === 16'h00C0 && pcnt[7:0] === hold, "halt");
		@(posedge ref_clk);
		halt_mode <= 1'b0;
		wr(2'h3, 8'h5A);
		check(pcnt === 16'h0000, "periodic clear");
		repeat (600) @(negedge ref_clk);
		check(pcnt === 16'h0002 || pcnt === 16'h0003, "periodic step");
		done("periodic");
		do_reset(1'b0, 1'b0);
		foreach (keys[i]) begin
			repeat (4) @(negedge ref_clk);
			wr(2'h0, keys[i]);
			check((gcnt === 16'h0000) == clr[i], "key sequence");
		end
		wr(2'h0, 8'h23);
		check(req_out === 1'b1 && gctl[7] === 1'b1, "bad key");
		do_reset(1'b0, 1'b0);
		check(gctl[7] === 1'b1 && req_out === 1'b0, "flag kept");
		wr(2'h1, 8'h28);
		check(gctl === 16'h0028 && krd === 16'h0028, "flag cleared");
		wr(2'h0, 8'h00);
		check(req_out === 1'b1, "second bad key");
		done("key");
		do_reset(1'b0, 1'b0);
		@(posedge ref_clk);
		raw <= 1'b1;
		wr(2'h1, 8'h30);
		check(req_out === 1'b0 && gctl[5:3] === 3'h6, "check bits stored");
		@(negedge ref_clk);
		check(req_out === 1'b1, "check bits reset");
		done("check bits");
		@(posedge ref_clk);
		raw <= 1'b0;
		do_reset(1'b0, 1'b0);
		wr(2'h1, 8'h07);
		wr(2'h0, 8'h55);
		wr(2'h0, 8'hAA);
		repeat (300) @(negedge ref_clk);
		check(gcnt === 16'h0002 || gcnt === 16'h0003, "prescale");
		done("prescale");
		do_reset(1'b0, 1'b0);
		wr(2'h1, 8'h68);
		check(gctl === 16'h0068 && krd === 16'h0068, "flag clear, disable bit, pin low");
		n = 0;
		while (gcnt !== 16'h00FF && n < 600) begin
			@(negedge ref_clk);
			n++;
		end
		while (gcnt !== 16'h0000 && n < 700) begin
			@(negedge ref_clk);
			n++;
		end
		check(req_out === 1'b0 && gctl[7] === 1'b1, "overflow flag");
		@(negedge ref_clk);
		check(req_out === 1'b0, "overflow delay");
		@(negedge ref_clk);
		check(req_out === 1'b1, "overflow reset");
		done("guard");
		finish_test();
	end
endmodule
`default_nettype wire
